// ---- rtl/pvs_top.v ----
`timescale 1ns/1ps
`include "pvs_consts.vh"
// Overview of operation
// - standard power-up starts only with battery and io supply present and the chip selected on both select pins.
// - in standard power-up, reaching usb_on_state releases power_on_reset_n and starts the pll.
// - dir stays high until the pll reports lock and then falls so the link may configure the part.
// - after reset the vbus drive bits are 0 and both data-line pulldown bits are 1.
// - charger detection power-up starts when unselected, vbus present, charger enable low and battery above monitor.
// - in charger detection power-up, usb_on_state keeps reset asserted, pll stopped and starts the charger machine.
// - a_vbus_valid_flag follows the a-device vbus-valid comparator.
// - session_valid_flag follows the session-valid comparator.
// - b_session_valid_flag follows the b-device session-valid comparator.
// - session_end_flag is 0 while vbus is above the session-end threshold and 1 otherwise.
// - two clock modes exist, 60 MHz input on the ulpi clock pin or a 19.2 or 26 MHz reference chosen by a select.
// - the ulpi clock pin is an input after reset and turns to an output once reference clock activity is seen.
module pvs_top
#(
    parameter SEQ_STEPS    = `PVS_SEQ_STEPS,
    parameter REFERENCE_CLOCK_IN_EDGES = `PVS_REFERENCE_CLOCK_IN_EDGES
)
(
    input  wire       clk,
    input  wire       rst_b,
    input  wire       battery_present,
    input  wire       io_supply,
    input  wire       chip_select,
    input  wire       chip_select_n,
    input  wire       vbus_present,
    input  wire       charger_detect_enable_n,
    input  wire       battery_above_monitor,
    input  wire       cmp_a_vbus_valid,
    input  wire       cmp_session_valid,
    input  wire       cmp_b_session_valid,
    input  wire       cmp_above_b_session_end,
    input  wire       reference_clock_in,
    input  wire       reference_clock_in_freq_select,
    input  wire       pll_lock,
    input  wire       reg_a_wr,
    input  wire [3:0] reg_a_wdata,
    output reg        power_on_reset_n,
    output reg        pll_start,
    output reg        dir,
    output reg        charger_fsm_start,
    output reg        usb_on_state,
    output reg        reg_a_wr_ack,
    output reg        drive_vbus_internal,
    output reg        drive_vbus_external,
    output reg        dplus_pulldown_en,
    output reg        dminus_pulldown_en,
    output reg        a_vbus_valid_flag,
    output reg        session_valid_flag,
    output reg        b_session_valid_flag,
    output reg        session_end_flag,
    output reg        ulpi_clk_out_en,
    output reg        pll_ref_26m_sel
);

    // ****************************************************************
    // derived counts
    // ****************************************************************
    localparam [31:0] STEP_CYC   = (`PVS_SEQ_STEP_NS + `PVS_CLK_PERIOD_NS - 1) / `PVS_CLK_PERIOD_NS;
    localparam [31:0] IDLE_CYC   = `PVS_REFERENCE_CLOCK_IN_IDLE_NS / `PVS_CLK_PERIOD_NS;
    localparam [31:0] STEPS_CNT  = SEQ_STEPS;
    localparam [31:0] EDGES_CNT  = REFERENCE_CLOCK_IN_EDGES;
    localparam [11:0] STEP_LAST  = STEP_CYC[11:0] - 12'h001;
    localparam [11:0] IDLE_LAST  = IDLE_CYC[11:0] - 12'h001;
    localparam [3:0]  STEPS_LAST = STEPS_CNT[3:0] - 4'h1;
    localparam [3:0]  EDGES_LAST = EDGES_CNT[3:0] - 4'h1;

    // ****************************************************************
    // input synchronisers
    // ****************************************************************
    wire [`PVS_SYNC_W-1:0] raw_in;
    wire [`PVS_SYNC_W-1:0] syn;
    wire                   ref_syn;

    assign raw_in = {cmp_above_b_session_end, cmp_b_session_valid,
                     cmp_session_valid, cmp_a_vbus_valid,
                     battery_above_monitor, charger_detect_enable_n,
                     vbus_present, chip_select_n, chip_select,
                     io_supply, battery_present};

    pvs_sync
    #(
        .W       (`PVS_SYNC_W),
        .RST_VAL (11'h028)
    )
    u_sync_levels
    (
        .clk   (clk),
        .rst_b (rst_b),
        .d_in  (raw_in),
        .q_out (syn)
    );

    pvs_sync
    #(
        .W       (1),
        .RST_VAL (1'b0)
    )
    u_sync_ref
    (
        .clk   (clk),
        .rst_b (rst_b),
        .d_in  (reference_clock_in),
        .q_out (ref_syn)
    );

    // ****************************************************************
    // power-up conditions
    // ****************************************************************
    wire selected;
    wire std_cond;
    wire chg_cond;

    assign selected = syn[`PVS_IN_CS] & ~syn[`PVS_IN_CS_N];
    assign std_cond = syn[`PVS_IN_BAT] & syn[`PVS_IN_IO] & selected;
    assign chg_cond = ~selected & syn[`PVS_IN_VBUS] &
                      ~syn[`PVS_IN_CHG_N] & syn[`PVS_IN_BAT_MON];

    // ****************************************************************
    // sequencer state machine
    // ****************************************************************
    reg [2:0]  state_reg;
    reg [2:0]  state_next;
    reg        mode_reg;
    reg        mode_next;
    reg [11:0] tick_reg;
    reg [11:0] tick_next;
    reg [3:0]  step_reg;
    reg [3:0]  step_next;
    wire       mode_ok;

    assign mode_ok = (mode_reg == `PVS_MODE_STD) ? std_cond : chg_cond;

    always @*
    begin
        state_next = state_reg;
        mode_next  = mode_reg;
        tick_next  = tick_reg;
        step_next  = step_reg;
        case (state_reg)
            `PVS_ST_OFF:
            begin
                tick_next = 12'h000;
                step_next = 4'h0;
                if (std_cond)
                begin
                    mode_next  = `PVS_MODE_STD;
                    state_next = `PVS_ST_SEQ;
                end
                else if (chg_cond)
                begin
                    mode_next  = `PVS_MODE_CHG;
                    state_next = `PVS_ST_SEQ;
                end
            end
            `PVS_ST_SEQ:
            begin
                if (!mode_ok)
                    state_next = `PVS_ST_OFF;
                else if (tick_reg == STEP_LAST)
                begin
                    tick_next = 12'h000;
                    if (step_reg == STEPS_LAST)
                        state_next = `PVS_ST_USB_ON;
                    else
                        step_next = step_reg + 4'h1;
                end
                else
                    tick_next = tick_reg + 12'h001;
            end
            `PVS_ST_USB_ON:
            begin
                if (!mode_ok)
                    state_next = `PVS_ST_OFF;
                else if (mode_reg == `PVS_MODE_STD)
                    state_next = `PVS_ST_PLL_WAIT;
                else
                    state_next = `PVS_ST_CHARGER;
            end
            `PVS_ST_PLL_WAIT:
            begin
                if (!mode_ok)
                    state_next = `PVS_ST_OFF;
                else if (pll_lock)
                    state_next = `PVS_ST_ACTIVE;
            end
            `PVS_ST_ACTIVE:
            begin
                if (!mode_ok)
                    state_next = `PVS_ST_OFF;
                else if (!pll_lock)
                    state_next = `PVS_ST_PLL_WAIT;
            end
            `PVS_ST_CHARGER:
            begin
                if (!mode_ok)
                    state_next = `PVS_ST_OFF;
            end
            default:
            begin
                state_next = `PVS_ST_OFF;
            end
        endcase
    end

    always @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            state_reg <= `PVS_ST_OFF;
            mode_reg  <= `PVS_MODE_STD;
            tick_reg  <= 12'h000;
            step_reg  <= 4'h0;
        end
        else
        begin
            state_reg <= state_next;
            mode_reg  <= mode_next;
            tick_reg  <= tick_next;
            step_reg  <= step_next;
        end
    end

    // ****************************************************************
    // sequencer outputs
    // ****************************************************************
    wire std_run;

    assign std_run = (state_next == `PVS_ST_PLL_WAIT) | (state_next == `PVS_ST_ACTIVE);

    always @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            power_on_reset_n  <= 1'b0;
            pll_start         <= 1'b0;
            dir               <= 1'b1;
            charger_fsm_start <= 1'b0;
            usb_on_state      <= 1'b0;
        end
        else
        begin
            power_on_reset_n  <= std_run;
            pll_start         <= std_run;
            dir               <= (state_next != `PVS_ST_ACTIVE);
            charger_fsm_start <= (state_next == `PVS_ST_CHARGER);
            usb_on_state      <= (state_next != `PVS_ST_OFF) & (state_next != `PVS_ST_SEQ);
        end
    end

    // ****************************************************************
    // reg_a bits written by the link
    // ****************************************************************
    wire wr_ok;

    assign wr_ok = reg_a_wr & power_on_reset_n & ~dir;

    always @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            drive_vbus_internal <= `PVS_RST_DRV_INT;
            drive_vbus_external <= `PVS_RST_DRV_EXT;
            dplus_pulldown_en   <= `PVS_RST_DP_PD;
            dminus_pulldown_en  <= `PVS_RST_DM_PD;
            reg_a_wr_ack        <= 1'b0;
        end
        else if (!power_on_reset_n)
        begin
            drive_vbus_internal <= `PVS_RST_DRV_INT;
            drive_vbus_external <= `PVS_RST_DRV_EXT;
            dplus_pulldown_en   <= `PVS_RST_DP_PD;
            dminus_pulldown_en  <= `PVS_RST_DM_PD;
            reg_a_wr_ack        <= 1'b0;
        end
        else
        begin
            reg_a_wr_ack <= wr_ok;
            if (wr_ok)
            begin
                drive_vbus_internal <= reg_a_wdata[`PVS_BIT_DRV_INT];
                drive_vbus_external <= reg_a_wdata[`PVS_BIT_DRV_EXT];
                dplus_pulldown_en   <= reg_a_wdata[`PVS_BIT_DP_PD];
                dminus_pulldown_en  <= reg_a_wdata[`PVS_BIT_DM_PD];
            end
        end
    end

    // ****************************************************************
    // vbus status flags
    // ****************************************************************
    always @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            a_vbus_valid_flag    <= 1'b0;
            session_valid_flag   <= 1'b0;
            b_session_valid_flag <= 1'b0;
            session_end_flag     <= 1'b1;
        end
        else
        begin
            a_vbus_valid_flag    <= syn[`PVS_IN_A_VLD];
            session_valid_flag   <= syn[`PVS_IN_SESS_VLD];
            b_session_valid_flag <= syn[`PVS_IN_B_VLD];
            session_end_flag     <= ~syn[`PVS_IN_B_END];
        end
    end

    // ****************************************************************
    // reference clock activity and clock mode
    // ****************************************************************
    reg        ref_prev_reg;
    reg [3:0]  edge_cnt_reg;
    reg [11:0] idle_cnt_reg;
    wire       ref_rise;

    assign ref_rise = ref_syn & ~ref_prev_reg;

    always @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            ref_prev_reg    <= 1'b0;
            edge_cnt_reg    <= 4'h0;
            idle_cnt_reg    <= 12'h000;
            ulpi_clk_out_en <= 1'b0;
            pll_ref_26m_sel <= 1'b0;
        end
        else
        begin
            ref_prev_reg    <= ref_syn;
            pll_ref_26m_sel <= reference_clock_in_freq_select;
            if (ref_rise)
            begin
                idle_cnt_reg <= 12'h000;
                if (edge_cnt_reg == EDGES_LAST)
                    ulpi_clk_out_en <= 1'b1;
                else
                    edge_cnt_reg <= edge_cnt_reg + 4'h1;
            end
            else if (idle_cnt_reg == IDLE_LAST)
            begin
                // a grounded reference keeps the pin an input
                edge_cnt_reg <= 4'h0;
            end
            else
                idle_cnt_reg <= idle_cnt_reg + 12'h001;
        end
    end
endmodule

// ---- rtl/pvs_consts.vh ----
`ifndef PVS_CONSTS_VH
`define PVS_CONSTS_VH

// ****************************************************************
// clock and timing
// ****************************************************************
`define PVS_CLK_PERIOD_NS   10
`define PVS_SEQ_STEP_NS     1000
`define PVS_SEQ_STEPS       4
`define PVS_REFERENCE_CLOCK_IN_EDGES    4
`define PVS_REFERENCE_CLOCK_IN_IDLE_NS  2000

// ****************************************************************
// sequencer state codes
// ****************************************************************
`define PVS_ST_OFF          3'h0
`define PVS_ST_SEQ          3'h1
`define PVS_ST_USB_ON       3'h2
`define PVS_ST_PLL_WAIT     3'h3
`define PVS_ST_ACTIVE       3'h4
`define PVS_ST_CHARGER      3'h5

// ****************************************************************
// power-up mode codes
// ****************************************************************
`define PVS_MODE_STD        1'b0
`define PVS_MODE_CHG        1'b1

// ****************************************************************
// reg_a write field positions and reset values
// ****************************************************************
`define PVS_BIT_DRV_INT     0
`define PVS_BIT_DRV_EXT     1
`define PVS_BIT_DP_PD       2
`define PVS_BIT_DM_PD       3
`define PVS_RST_DRV_INT     1'b0
`define PVS_RST_DRV_EXT     1'b0
`define PVS_RST_DP_PD       1'b1
`define PVS_RST_DM_PD       1'b1

// ****************************************************************
// synchroniser lanes
// ****************************************************************
`define PVS_SYNC_W          11
`define PVS_IN_BAT          0
`define PVS_IN_IO           1
`define PVS_IN_CS           2
`define PVS_IN_CS_N         3
`define PVS_IN_VBUS         4
`define PVS_IN_CHG_N        5
`define PVS_IN_BAT_MON      6
`define PVS_IN_A_VLD        7
`define PVS_IN_SESS_VLD     8
`define PVS_IN_B_VLD        9
`define PVS_IN_B_END        10

`endif

// ---- rtl/pvs_sync.v ----
`timescale 1ns/1ps
// ****************************************************************
// three-flop synchroniser with agreement filter
// ****************************************************************
module pvs_sync
#(
    parameter W = 1,
    parameter [W-1:0] RST_VAL = {W{1'b0}}
)
(
    input  wire         clk,
    input  wire         rst_b,
    input  wire [W-1:0] d_in,
    output reg  [W-1:0] q_out
);
    reg [W-1:0] s1_reg;
    reg [W-1:0] s2_reg;
    reg [W-1:0] s3_reg;
    integer     i;

    always @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            s1_reg <= RST_VAL;
            s2_reg <= RST_VAL;
            s3_reg <= RST_VAL;
            q_out  <= RST_VAL;
        end
        else
        begin
            s1_reg <= d_in;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            // a lane changes only when stages two and three agree
            for (i = 0; i < W; i = i + 1)
            begin
                if (s2_reg[i] == s3_reg[i])
                    q_out[i] <= s3_reg[i];
            end
        end
    end
endmodule

// ---- sim/pvs_properties.sv ----
`timescale 1ns/1ps
// ****************************************************************
// port checker
// ****************************************************************
module pvs_properties
(
    input wire       clk,
    input wire       rst_b,
    input wire       chip_select,
    input wire       chip_select_n,
    input wire       cmp_a_vbus_valid,
    input wire       cmp_above_b_session_end,
    input wire       reference_clock_in_freq_select,
    input wire       pll_lock,
    input wire       reg_a_wr,
    input wire [3:0] reg_a_wdata,
    input wire       power_on_reset_n,
    input wire       pll_start,
    input wire       dir,
    input wire       charger_fsm_start,
    input wire       usb_on_state,
    input wire       reg_a_wr_ack,
    input wire       drive_vbus_internal,
    input wire       drive_vbus_external,
    input wire       dplus_pulldown_en,
    input wire       dminus_pulldown_en,
    input wire       a_vbus_valid_flag,
    input wire       session_end_flag,
    input wire       ulpi_clk_out_en,
    input wire       pll_ref_26m_sel
);
    wire [3:0] reg_a_q = {dminus_pulldown_en, dplus_pulldown_en, drive_vbus_external, drive_vbus_internal};
    reg  [3:0] up_cnt_reg;

    // cycles since reset release, saturating
    always @(posedge clk or negedge rst_b)
        if (!rst_b)
            up_cnt_reg <= 4'h0;
        else if (up_cnt_reg != 4'hf)
            up_cnt_reg <= up_cnt_reg + 4'h1;

    default clocking dc @(posedge clk);
    endclocking
    default disable iff (!rst_b);

    por_needs_usb_on_state_a: assert property (power_on_reset_n |-> usb_on_state)
        else $error("reset released outside usb on state");
    pll_with_por_a: assert property (pll_start == power_on_reset_n)
        else $error("pll run and reset release disagree");
    std_needs_select_a: assert property ($rose(power_on_reset_n) |-> $past(chip_select && !chip_select_n, 8))
        else $error("standard power-up without selection");
    dir_waits_lock_a: assert property ($fell(dir) |-> $past(pll_lock) && power_on_reset_n)
        else $error("dir fell without pll lock");
    dir_until_por_a: assert property (!power_on_reset_n |-> dir)
        else $error("dir low while held in reset");
    charger_holds_reset_a: assert property (charger_fsm_start |-> !power_on_reset_n && !pll_start && usb_on_state)
        else $error("charger mode released reset or pll");
    write_refused_a: assert property (reg_a_wr && !(power_on_reset_n && !dir) |=> !reg_a_wr_ack &&
        ($past(power_on_reset_n) ? $stable(reg_a_q) : reg_a_q == 4'hc))
        else $error("write taken while link not owner");
    write_taken_a: assert property (reg_a_wr && power_on_reset_n && !dir |=> reg_a_wr_ack && reg_a_q == $past(reg_a_wdata))
        else $error("write not taken or wrong value");
    reset_values_a: assert property (!power_on_reset_n ##1 !power_on_reset_n |-> reg_a_q == 4'hc)
        else $error("reg_a bits off reset value");
    vbus_flag_follow_a: assert property ($changed(a_vbus_valid_flag) |-> a_vbus_valid_flag == $past(cmp_a_vbus_valid, 4))
        else $error("vbus valid flag moved without comparator");
    sess_end_inverted_a: assert property ((up_cnt_reg == 4'hf && $stable(cmp_above_b_session_end))[*7] |->
        session_end_flag == !cmp_above_b_session_end)
        else $error("session end flag not inverted comparator");
    clk_out_sticky_a: assert property (ulpi_clk_out_en |=> ulpi_clk_out_en)
        else $error("clock output enable dropped");
    ref_sel_follow_a: assert property ($past(rst_b) |-> pll_ref_26m_sel == $past(reference_clock_in_freq_select))
        else $error("reference select copy wrong");

    cover property ($fell(dir));
    cover property (reg_a_wr_ack);
    cover property ($rose(charger_fsm_start));
    cover property ($rose(ulpi_clk_out_en));
endmodule

bind pvs_top pvs_properties u_chk (.clk(clk), .rst_b(rst_b), .chip_select(chip_select), .chip_select_n(chip_select_n),
    .cmp_a_vbus_valid(cmp_a_vbus_valid), .cmp_above_b_session_end(cmp_above_b_session_end),
    .reference_clock_in_freq_select(reference_clock_in_freq_select), .pll_lock(pll_lock), .reg_a_wr(reg_a_wr), .reg_a_wdata(reg_a_wdata),
    .power_on_reset_n(power_on_reset_n), .pll_start(pll_start), .dir(dir), .charger_fsm_start(charger_fsm_start),
    .usb_on_state(usb_on_state), .reg_a_wr_ack(reg_a_wr_ack), .drive_vbus_internal(drive_vbus_internal),
    .drive_vbus_external(drive_vbus_external), .dplus_pulldown_en(dplus_pulldown_en),
    .dminus_pulldown_en(dminus_pulldown_en), .a_vbus_valid_flag(a_vbus_valid_flag),
    .session_end_flag(session_end_flag), .ulpi_clk_out_en(ulpi_clk_out_en), .pll_ref_26m_sel(pll_ref_26m_sel));

// ---- sim/pvs_link_model.sv ----
`timescale 1ns/1ps
// ****************************************************************
// link controller model
// ****************************************************************
module pvs_link_model
(
    input  wire       clk,
    input  wire       dir,
    input  wire       power_on_reset_n,
    input  wire       go,
    input  wire [3:0] go_data,
    input  wire       force_wr,
    output reg        reg_a_wr,
    output reg  [3:0] reg_a_wdata
);
    initial
    begin
        reg_a_wr = 1'b0;
        reg_a_wdata = 4'h0;
    end
    // strobe only once the link owns the bus, unless told to break in early
    always @(negedge clk)
    begin
        reg_a_wr <= go & (force_wr | (power_on_reset_n & ~dir));
        reg_a_wdata <= go ? go_data : ~reg_a_wdata;
    end
endmodule

// ---- sim/pvs_top_test.sv ----
`timescale 1ns/1ps
module pvs_top_test;
    // ****************************************************************
    // signals
    // ****************************************************************
    reg         clk, rst_b, battery_present, io_supply, chip_select, chip_select_n;
    reg         vbus_present, charger_detect_enable_n, battery_above_monitor;
    reg         reference_clock_in, ref_run, reference_clock_in_freq_select, pll_lock, go, force_wr;
    reg  [3:0]  cmp, cmp_old, go_data;
    reg  [31:0] seed;
    integer     n_errors, total_checks, n_ack, k;
    wire        reg_a_wr, power_on_reset_n, pll_start, dir, charger_fsm_start, usb_on_state;
    wire        reg_a_wr_ack, drive_vbus_internal, drive_vbus_external, dplus_pulldown_en;
    wire        dminus_pulldown_en, a_vbus_valid_flag, session_valid_flag, b_session_valid_flag;
    wire        session_end_flag, ulpi_clk_out_en, pll_ref_26m_sel;
    wire [3:0]  reg_a_wdata;
    wire [3:0]  reg_a_q = {dminus_pulldown_en, dplus_pulldown_en, drive_vbus_external, drive_vbus_internal};
    wire [3:0]  flags   = {session_end_flag, b_session_valid_flag, session_valid_flag, a_vbus_valid_flag};
    wire [3:0]  seq_q   = {power_on_reset_n, pll_start, dir, usb_on_state};
    wire [3:0]  evt     = {charger_fsm_start, ulpi_clk_out_en, ~dir, power_on_reset_n};

    pvs_top #(.SEQ_STEPS(1), .REFERENCE_CLOCK_IN_EDGES(4)) DUT (.clk(clk), .rst_b(rst_b), .battery_present(battery_present),
        .io_supply(io_supply), .chip_select(chip_select), .chip_select_n(chip_select_n), .vbus_present(vbus_present),
        .charger_detect_enable_n(charger_detect_enable_n), .battery_above_monitor(battery_above_monitor),
        .cmp_a_vbus_valid(cmp[0]), .cmp_session_valid(cmp[1]), .cmp_b_session_valid(cmp[2]),
        .cmp_above_b_session_end(cmp[3]), .reference_clock_in(reference_clock_in),
        .reference_clock_in_freq_select(reference_clock_in_freq_select), .pll_lock(pll_lock), .reg_a_wr(reg_a_wr), .reg_a_wdata(reg_a_wdata),
        .power_on_reset_n(power_on_reset_n), .pll_start(pll_start), .dir(dir), .charger_fsm_start(charger_fsm_start),
        .usb_on_state(usb_on_state), .reg_a_wr_ack(reg_a_wr_ack), .drive_vbus_internal(drive_vbus_internal),
        .drive_vbus_external(drive_vbus_external), .dplus_pulldown_en(dplus_pulldown_en),
        .dminus_pulldown_en(dminus_pulldown_en), .a_vbus_valid_flag(a_vbus_valid_flag),
        .session_valid_flag(session_valid_flag), .b_session_valid_flag(b_session_valid_flag),
        .session_end_flag(session_end_flag), .ulpi_clk_out_en(ulpi_clk_out_en), .pll_ref_26m_sel(pll_ref_26m_sel));

    pvs_link_model u_link (.clk(clk), .dir(dir), .power_on_reset_n(power_on_reset_n), .go(go), .go_data(go_data),
        .force_wr(force_wr), .reg_a_wr(reg_a_wr), .reg_a_wdata(reg_a_wdata));

    // ****************************************************************
    // clocks and helpers
    // ****************************************************************
    always #5 clk = ~clk;

    initial
    begin
        #3;
        forever
        begin
            #40;
            reference_clock_in = ref_run ? ~reference_clock_in : 1'b0;
        end
    end

    always @(posedge clk)
        if (reg_a_wr_ack === 1'b1)
            n_ack = n_ack + 1;

    function [31:0] xs(input [31:0] s);
        reg [31:0] t;
        begin
            t = s ^ (s << 13);
            t = t ^ (t >> 17);
            xs = t ^ (t << 5);
        end
    endfunction

    function [3:0] exp_flags(input [3:0] c);
        begin
            exp_flags = {~c[3], c[2:0]};
        end
    endfunction

    task wrap_up;
        begin
            if (n_errors == 0 && total_checks > 0)
                $display("No errors found");
            else
                $display("Errors were found");
            $finish;
        end
    endtask

    task chk(input [3:0] got, input [3:0] exp);
        begin
            total_checks = total_checks + 1;
            if (got !== exp)
            begin
                n_errors = n_errors + 1;
                $display("FAIL %0t got %h expected %h", $time, got, exp);
            end
        end
    endtask

    task wait_on(input [1:0] which, input integer lim);
        integer i;
        begin
            i = 0;
            while (i < lim && evt[which] !== 1'b1)
            begin
                @(negedge clk);
                i = i + 1;
            end
            if (i >= lim)
            begin
                n_errors = n_errors + 1;
                $display("FAIL %0t wait ran out", $time);
                wrap_up;
            end
        end
    endtask

    task link_write(input [3:0] d);
        begin
            go <= 1'b1;
            go_data <= d;
            @(negedge clk);
            go <= 1'b0;
            repeat (3) @(negedge clk);
        end
    endtask

    // ****************************************************************
    // main sequence
    // ****************************************************************
    initial
    begin
        {clk, rst_b, battery_present, io_supply, chip_select, vbus_present, battery_above_monitor} = 7'h0;
        {reference_clock_in, ref_run, reference_clock_in_freq_select, pll_lock, go, force_wr} = 6'h0;
        {chip_select_n, charger_detect_enable_n} = 2'h3;
        cmp = 4'h8;
        go_data = 4'h0;
        seed = 32'h45;
        n_errors = 0;
        total_checks = 0;
        n_ack = 0;
        repeat (16) @(negedge clk);
        rst_b = 1'b1;
        @(negedge clk);
        chk(reg_a_q, 4'hc);
        chk(seq_q, 4'h2);
        chk({3'h0, ulpi_clk_out_en}, 4'h0);
        force_wr = 1'b1;
        link_write(4'h3);
        force_wr = 1'b0;
        chk(reg_a_q, 4'hc);
        chk(n_ack[3:0], 4'h0);
        for (k = 0; k < 14; k = k + 1)
        begin
            seed = xs(seed);
            cmp_old = cmp;
            cmp <= (k == 0) ? 4'hf : (k == 1) ? 4'h0 : seed[3:0];
            @(negedge clk);
            chk(flags, exp_flags(cmp_old));
            repeat (5) @(negedge clk);
            chk(flags, exp_flags(cmp));
        end
        {battery_present, io_supply, chip_select} = 3'h7;
        repeat (150) @(negedge clk);
        chk(seq_q, 4'h2);
        chip_select_n = 1'b0;
        wait_on(2'd0, 300);
        chk(seq_q, 4'hf);
        repeat (4) @(negedge clk);
        chk(seq_q, 4'hf);
        pll_lock = 1'b1;
        wait_on(2'd1, 4);
        chk(seq_q, 4'hd);
        link_write(4'h2);
        chk(reg_a_q, 4'h2);
        for (k = 0; k < 8; k = k + 1)
        begin
            seed = xs(seed);
            link_write(seed[3:0]);
            chk(reg_a_q, seed[3:0]);
        end
        chk(n_ack[3:0], 4'h9);
        pll_lock = 1'b0;
        repeat (3) @(negedge clk);
        chk(seq_q, 4'hf);
        force_wr = 1'b1;
        link_write(~seed[3:0]);
        force_wr = 1'b0;
        chk(reg_a_q, seed[3:0]);
        pll_lock = 1'b1;
        wait_on(2'd1, 4);
        reference_clock_in_freq_select = 1'b1;
        ref_run = 1'b1;
        repeat (20) @(negedge clk);
        chk({pll_ref_26m_sel, 2'h0, ulpi_clk_out_en}, 4'h8);
        wait_on(2'd2, 40);
        reference_clock_in_freq_select = 1'b0;
        ref_run = 1'b0;
        repeat (2) @(negedge clk);
        chk({pll_ref_26m_sel, 2'h0, ulpi_clk_out_en}, 4'h1);
        {chip_select, vbus_present, battery_above_monitor} = 3'h3;
        repeat (150) @(negedge clk);
        chk(seq_q, 4'h2);
        chk(reg_a_q, 4'hc);
        charger_detect_enable_n = 1'b0;
        wait_on(2'd3, 300);
        chk(seq_q, 4'h3);
        wrap_up;
    end
endmodule
